// [logic/mdp_pkg.sv]
// Summary of operation
// (RULE1) with the maintenance cable absent the processor runs normally and ignores the port.
// (RULE2) sixteen display outputs present one of seven selectable signal groups during a direct access.
// (RULE3) the subcontroller forwards the display group onto the host bus only on a direct read.
// (RULE4) only control bits 29 to 31 are used: I/O reset, phase stop during service, single phase.
// (RULE5) on a direct read group address bits 13 to 15 choose which display group is shown.
// (RULE6) the subcontroller holds the read/write indicator high for writes and low for reads.
// (RULE7) a strobe from the subcontroller makes the processor act on the current inputs.
// (RULE8) an open subcontroller-presence input makes the processor ignore all other port inputs.
// (RULE9) the active-low single-phase indicator is driven low while in single-phase mode.
// (RULE10) the strobe is synchronised and exactly one action is taken per strobe assertion.
package mdp_pkg;
   localparam int DISP_W      = 16;
   localparam int CTRL_W      = 16;
   localparam int ADDR_W      = 7;
   localparam int GROUPS      = 7;
   localparam int SEL_W       = 3;
   // control lines carry host bits 16..31; index k is host bit 16+k
   localparam int CTRL_BASE   = 16;
   localparam int BIT_RESET   = 29 - CTRL_BASE;
   localparam int BIT_PSTOP   = 30 - CTRL_BASE;
   localparam int BIT_SPHASE  = 31 - CTRL_BASE;
   // address lines carry host bits 9..15
   localparam int ADDR_BASE   = 9;
   localparam int SEL_LO      = 13 - ADDR_BASE;
   localparam int SEL_HI      = 15 - ADDR_BASE;
   localparam logic [DISP_W-1:0] DISP_RST = 16'h0000;
   localparam logic [SEL_W-1:0]  SEL_RST  = 3'h0;
   // bus side
   localparam logic [31:0] A_DISP_SEL  = 32'h0000_0000;
   localparam logic [31:0] A_CTRL      = 32'h0000_0004;
   localparam logic [31:0] A_STATUS    = 32'h0000_0008;
   localparam logic [31:0] A_GROUP0    = 32'h0000_0010;
   localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
   localparam logic [2:0]  HSIZE_WORD  = 3'h2;
endpackage

// [logic/mdp_sync.sv]
module mdp_sync
   import mdp_pkg::*;
#(
   parameter int W = 1
)(
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
      end
   end
   assign q = s2_r;
endmodule

// [logic/mdp_group_mux.sv]
module mdp_group_mux
   import mdp_pkg::*;
(
   input  wire logic [GROUPS*DISP_W-1:0] groups,
   input  wire logic [SEL_W-1:0]         sel,
   output logic      [DISP_W-1:0]        y
);
   // codes beyond the seventh group read as zero
   always_comb begin
      y = '0;
      if (int'(sel) < GROUPS) begin
         y = groups[int'(sel)*DISP_W +: DISP_W];
      end
   end
endmodule

// [logic/mdp_port.sv]
module mdp_port
   import mdp_pkg::*;
(
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output logic      [31:0]              hrdata,
   output logic                          hreadyout,
   output logic                          hresp,
   input  wire logic [GROUPS*DISP_W-1:0] internal_groups,
   input  wire logic [CTRL_W-1:0]        control_input_lines,
   input  wire logic [ADDR_W-1:0]        group_address_lines,
   input  wire logic                     read_write_indicator,
   input  wire logic                     port_strobe,
   input  wire logic                     subcontroller_present_n,
   output logic      [DISP_W-1:0]        display_outputs,
   output logic                          single_phase_indicator_n,
   output logic                          io_reset_pulse,
   output logic                          phase_stop,
   output logic                          single_phase
);
   localparam int PIN_W = CTRL_W + ADDR_W + 3;
   logic [PIN_W-1:0]  pins_raw;
   logic [PIN_W-1:0]  pins_s;
   logic [CTRL_W-1:0] ctl_s;
   logic [ADDR_W-1:0] adr_s;
   logic              rw_s;
   logic              stb_s;
   logic              absent_s;
   logic              stb_d_r;
   logic              stb_d_nxt;
   logic              act;
   logic [SEL_W-1:0]  sel_r;
   logic [SEL_W-1:0]  sel_nxt;
   logic [SEL_W-1:0]  bus_sel_r;
   logic [SEL_W-1:0]  bus_sel_nxt;
   logic              pstop_r;
   logic              pstop_nxt;
   logic              sphase_r;
   logic              sphase_nxt;
   logic              rst_r;
   logic              rst_nxt;
   logic [DISP_W-1:0] disp_r;
   logic [DISP_W-1:0] disp_nxt;
   logic [DISP_W-1:0] mux_y;
   logic [DISP_W-1:0] bus_y;
   logic              wr_pend_r;
   logic              wr_pend_nxt;
   logic [31:0]       wr_addr_r;
   logic [31:0]       wr_addr_nxt;
   logic [31:0]       rdata_r;
   logic [31:0]       rdata_nxt;
   logic              take;

   assign pins_raw = {control_input_lines, group_address_lines,
                      read_write_indicator, port_strobe,
                      subcontroller_present_n};

   // presence pin floats high when open; syncs reset low so the port
   // counts as present until the pin has really been seen
   mdp_sync #(.W(PIN_W)) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       (pins_raw),
      .q       (pins_s)
   );

   assign ctl_s    = pins_s[PIN_W-1 -: CTRL_W];
   assign adr_s    = pins_s[ADDR_W+2:3];
   assign rw_s     = pins_s[2];
   assign stb_s    = pins_s[1];
   assign absent_s = pins_s[0];

   // rising edge of the synced strobe, gated by presence
   assign act = stb_s & ~stb_d_r & ~absent_s; // see (RULE10) see (RULE8)

   mdp_group_mux u_mux (
      .groups (internal_groups),
      .sel    (sel_r),
      .y      (mux_y)
   );

   mdp_group_mux u_bmux (
      .groups (internal_groups),
      .sel    (bus_sel_r),
      .y      (bus_y)
   );

   assign take = hsel & hready & (htrans == HTRANS_NSEQ)
                 & (hsize == HSIZE_WORD);
   always_comb begin
      stb_d_nxt   = stb_s;
      sel_nxt     = sel_r;
      pstop_nxt   = pstop_r;
      sphase_nxt  = sphase_r;
      rst_nxt     = 1'b0;
      bus_sel_nxt = bus_sel_r;
      wr_pend_nxt = take & hwrite;
      wr_addr_nxt = take ? haddr : wr_addr_r;
      rdata_nxt   = rdata_r;
      if (act) begin // see (RULE7)
         if (rw_s) begin
            // direct write: only the top three control bits matter
            rst_nxt    = ctl_s[BIT_RESET]; // see (RULE4)
            pstop_nxt  = ctl_s[BIT_PSTOP]; // see (RULE4)
            sphase_nxt = ctl_s[BIT_SPHASE]; // see (RULE4)
         end else begin
            sel_nxt = adr_s[SEL_HI:SEL_LO]; // see (RULE5)
         end
      end
      // pulling the cable must not leave the processor stopped
      if (absent_s) begin // see (RULE1)
         pstop_nxt  = 1'b0;
         sphase_nxt = 1'b0;
      end
      if (wr_pend_r) begin
         if (wr_addr_r == A_DISP_SEL) begin
            bus_sel_nxt = hwdata[SEL_W-1:0];
         end
         if (wr_addr_r == A_CTRL) begin
            rst_nxt = rst_nxt | hwdata[BIT_RESET];
         end
      end
      if (take && !hwrite) begin
         case (haddr)
            A_DISP_SEL: rdata_nxt = {29'h0, bus_sel_r};
            A_CTRL:     rdata_nxt = {16'h0, 13'h0, sphase_r, pstop_r,
                                     1'b0};
            A_STATUS:   rdata_nxt = {16'h0, disp_r};
            A_GROUP0:   rdata_nxt = {16'h0, bus_y};
            default:    rdata_nxt = 32'h0000_0000;
         endcase
      end
      disp_nxt = mux_y; // see (RULE2)
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stb_d_r   <= 1'b1;
         sel_r     <= SEL_RST;
         bus_sel_r <= SEL_RST;
         pstop_r   <= 1'b0;
         sphase_r  <= 1'b0;
         rst_r     <= 1'b0;
         disp_r    <= DISP_RST;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 32'h0000_0000;
         rdata_r   <= 32'h0000_0000;
      end else begin
         stb_d_r   <= stb_d_nxt;
         sel_r     <= sel_nxt;
         bus_sel_r <= bus_sel_nxt;
         pstop_r   <= pstop_nxt;
         sphase_r  <= sphase_nxt;
         rst_r     <= rst_nxt;
         disp_r    <= disp_nxt;
         wr_pend_r <= wr_pend_nxt;
         wr_addr_r <= wr_addr_nxt;
         rdata_r   <= rdata_nxt;
      end
   end

   assign display_outputs          = disp_r;
   assign single_phase_indicator_n = ~sphase_r; // see (RULE9)
   assign io_reset_pulse           = rst_r;
   assign phase_stop               = pstop_r;
   assign single_phase             = sphase_r;
   assign hrdata                   = rdata_r;
   assign hreadyout                = 1'b1;
   assign hresp                    = 1'b0;
endmodule

// [verification/mdp_port_properties.sv]
module mdp_port_chk
   import mdp_pkg::*;
(
   input wire logic              hclk,
   input wire logic              hresetn,
   input wire logic              hreadyout,
   input wire logic              hresp,
   input wire logic              hsel,
   input wire logic              hwrite,
   input wire logic [CTRL_W-1:0] control_input_lines,
   input wire logic              read_write_indicator,
   input wire logic              port_strobe,
   input wire logic              subcontroller_present_n,
   input wire logic              single_phase_indicator_n,
   input wire logic              io_reset_pulse,
   input wire logic              phase_stop,
   input wire logic              single_phase
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   bus_okay_a: assert property (
      hreadyout && !hresp) else $error("bus not ready or in error");
   ind_level_a: assert property (
      $stable(single_phase) |-> single_phase_indicator_n != single_phase)
      else $error("indicator does not follow single phase");
   absent_clear_a: assert property (
      subcontroller_present_n [*6] |-> !phase_stop && !single_phase)
      else $error("modes kept while port absent");
   absent_quiet_a: assert property (
      subcontroller_present_n [*6] |-> !io_reset_pulse)
      else $error("reset pulse while port absent");
   pulse_once_a: assert property (
      io_reset_pulse |=> !io_reset_pulse [*3])
      else $error("reset pulse too long or repeated");
   pulse_cause_a: assert property (
      io_reset_pulse |-> ($past(port_strobe, 2)
      && $past(read_write_indicator, 2)
      && $past(control_input_lines[BIT_RESET], 2))
      || ($past(hsel, 2) && $past(hwrite, 2))) else $error("stray pulse");
   pstop_cause_a: assert property (
      $rose(phase_stop) |-> $past(port_strobe, 2) && $past(read_write_indicator,
      2) && $past(control_input_lines[BIT_PSTOP], 2)) else $error("stray stop");
   sphase_cause_a: assert property (
      $rose(single_phase) |-> $past(port_strobe, 2) && $past(
      read_write_indicator, 2) && $past(control_input_lines[BIT_SPHASE], 2))
      else $error("stray single phase");
   sphase_drop_a: assert property (
      $fell(single_phase) |-> $past(port_strobe, 2) || subcontroller_present_n)
      else $error("single phase left without strobe");
endmodule

// [verification/mdp_subctl.sv]
module mdp_subctl
   import mdp_pkg::*;
(
   input  wire logic              hclk,
   input  wire logic [DISP_W-1:0] display_outputs,
   output logic      [CTRL_W-1:0] control_input_lines,
   output logic      [ADDR_W-1:0] group_address_lines,
   output logic                   read_write_indicator,
   output logic                   port_strobe,
   output logic                   subcontroller_present_n
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {control_input_lines, group_address_lines} = '0;
      {read_write_indicator, port_strobe, subcontroller_present_n} = 3'h0;
   end
   task automatic access(input logic wr, input logic [CTRL_W-1:0] c,
      input logic [ADDR_W-1:0] a, input int hold, output logic [15:0] q);
      @(posedge hclk);
      control_input_lines <= c;
      group_address_lines <= a;
      read_write_indicator <= wr;
      repeat (3) @(posedge hclk);
      port_strobe <= 1'b1;
      repeat (hold) @(posedge hclk);
      port_strobe <= 1'b0;
      repeat (6) @(posedge hclk);
      q = wr ? '0 : display_outputs;
   endtask
   // an open cable floats, so the pins are modelled as toggling noise
   task automatic unplug(input int n);
      @(posedge hclk);
      subcontroller_present_n <= 1'b1;
      repeat (n) begin
         @(posedge hclk);
         control_input_lines <= ~control_input_lines;
         group_address_lines <= ~group_address_lines;
         read_write_indicator <= ~read_write_indicator;
         port_strobe <= ~port_strobe;
      end
      @(posedge hclk);
      port_strobe <= 1'b0;
      repeat (4) @(posedge hclk);
      subcontroller_present_n <= 1'b0;
      repeat (4) @(posedge hclk);
   endtask
endmodule

// [verification/testbench.sv]
module testbench;
   import mdp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic                     hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
   logic                     hwrite = 1'b0, hreadyout, hresp, port_strobe;
   logic [1:0]               htrans = 2'h0;
   logic [2:0]               hsize = 3'h0;
   logic [31:0]              haddr = 32'h0, hwdata = 32'h0, q, hrdata;
   logic [GROUPS*DISP_W-1:0] internal_groups;
   logic [DISP_W-1:0]        d, display_outputs;
   logic [CTRL_W-1:0]        control_input_lines;
   logic [ADDR_W-1:0]        group_address_lines;
   logic                     single_phase_indicator_n, io_reset_pulse;
   logic                     phase_stop, single_phase, read_write_indicator;
   logic                     subcontroller_present_n;
   logic [15:0]              wt [4] = '{16'h1FFF, 16'h2000, 16'hE000,
                                        16'hC000};
   int                       n_errors = 0, num_checks = 0, n_pulse = 0, ep = 0;
   mdp_port uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .internal_groups, .control_input_lines, .group_address_lines,
      .read_write_indicator, .port_strobe, .subcontroller_present_n,
      .display_outputs, .single_phase_indicator_n, .io_reset_pulse,
      .phase_stop, .single_phase);
   mdp_subctl sub (.hclk, .display_outputs, .control_input_lines,
      .group_address_lines, .read_write_indicator, .port_strobe,
      .subcontroller_present_n);
   // the unused eighth select shows zero
   function automatic logic [DISP_W-1:0] grp(input int k);
      return k < GROUPS ? DISP_W'(16'h1111 * (k + 1)) : '0;
   endfunction
   task automatic chk(input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, wd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      hsize <= HSIZE_WORD;
      htrans <= HTRANS_NSEQ;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task final_report;
      if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always #25 hclk = ~hclk;
   always @(posedge hclk) if (io_reset_pulse === 1'b1) n_pulse++;
   initial for (int k = 0; k < GROUPS; k++)
      internal_groups[k*DISP_W +: DISP_W] = grp(k);
   initial begin
      repeat (5000) @(posedge hclk);
      n_errors++;
      final_report;
   end
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      chk(single_phase_indicator_n, 1);
      for (int s = 0; s < 8; s++) begin
         sub.access(1'b0, 16'hFFFF, ADDR_W'(s << 4), 6, d);
         chk(d, grp(s));
         chk(display_outputs, grp(s));
      end
      chk(n_pulse, 0);
      for (int i = 0; i < 4; i++) begin
         sub.access(1'b1, wt[i], 7'h20, 4 + 2 * i, d);
         ep += wt[i][13];
         chk(n_pulse, ep);
         chk(phase_stop, wt[i][14]);
         chk(single_phase_indicator_n, !wt[i][15]);
         chk(display_outputs, 0);
      end
      bus(1'b0, A_CTRL, 0);
      chk(q, 32'h6);
      sub.unplug(12);
      chk(phase_stop | single_phase, 0);
      chk(n_pulse, ep);
      sub.access(1'b1, 16'h2000, 7'h0, 4, d);
      chk(n_pulse, ep + 1);
      bus(1'b1, A_DISP_SEL, 3);
      bus(1'b0, A_GROUP0, 0);
      chk(q, grp(3));
      bus(1'b0, 32'h20, 0);
      chk(q, 0);
      bus(1'b1, A_CTRL, 32'h0000_2000);
      repeat (2) @(posedge hclk);
      chk(n_pulse, ep + 2);
      sub.access(1'b0, 16'h0000, 7'h20, 4, d);
      bus(1'b0, A_STATUS, 0);
      chk(q, grp(2));
      final_report;
   end
endmodule
bind mdp_port mdp_port_chk chk_i (.hclk, .hresetn, .hreadyout, .hresp,
   .hsel, .hwrite,
   .control_input_lines, .read_write_indicator, .port_strobe,
   .subcontroller_present_n, .single_phase_indicator_n, .io_reset_pulse,
   .phase_stop, .single_phase);
